// *** design/chgmc_top.sv ***
/*
 Charger mode control: mode decode, input protection, boost sequencing
 and an I2C register slave. Assumes sense levels and I2C pins are
 asynchronous; all are double-synchronised before use.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - 3-bit input floor field, resets to 100
// - Ramp charge current until cap or floor
// - Over-temperature suspends charge, fault code 101
// - VBUS below minimum terminates charging
// - OVP suspends; clears at hysteresis; revalidate
// - Inserted overcharged battery without cutoff stops PWM
// - Default settings charge to 4.2V
// - Input cap 500mA after VBUS insertion; here set to 500mA only at reset and on watchdog expiry
// - Status field at register 0 bits 5:4
// - Mode decoded from pin and two bits
// - Boost off clears operation select
// - High-z select disables boost only
// - VBUS above reference inhibits boost pulses
// - Soft start 50us at 1.5x limit
// - Switch held off while feedback above reference
// - Boost fault pulses status, clears select
// - SDA open drain, MSB first
// - Slave address 1101010
// - SDA sampled on SCL rising edge
// - Drive zero to acknowledge
// - 32s boost watchdog restores defaults
// - Termination with source sets done code 10
// - VBUS valid 25ms before charging
module chgmc_top
   import chgmc_pkg::*;
#(
   parameter int unsigned  VALID_CYCLES = VALID_CYC,
   parameter longint unsigned WDOG_CYCLES = WDOG_CYC
) (
   input  wire  logic         ref_clk_i,
   input  wire  logic         rst_b_i,
   input  wire  logic         scl_i,
   input  wire  logic         sda_i,
   output logic               sda_o,
   output logic               sda_oe_o,
   input  wire  logic         charger_off_i,
   input  wire  chgmc_sense_s sense_i,
   output chgmc_mode_e        mode_o,
   output logic               charge_en_o,
   output logic               ramp_up_o,
   output logic               hold_floor_o,
   output logic               pwm_stop_o,
   output logic [1:0]         input_current_cap_o,
   output logic [2:0]         charge_current_cap_o,
   output logic [5:0]         float_voltage_setting_o,
   output logic [2:0]         input_voltage_floor_o,
   output logic [1:0]         status_o,
   output logic [2:0]         fault_code_o,
   output logic               status_pin_o,
   output logic               boost_switch_o,
   output logic               pulse_skip_regime_o,
   output logic               long_on_time_o,
   output logic               soft_start_o,
   output logic               peak_limit_150_o
);
   // Two-flop synchronisers for every asynchronous level
   localparam int unsigned NS = $bits(chgmc_sense_s) + 3;
   logic [NS-1:0] sy1_r, sy2_r;
   wire  [NS-1:0] async_w = {sense_i, charger_off_i, scl_i, sda_i};
   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_sync
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               // SCL and SDA rest high, so no false edge follows reset
               sy1_r[g] <= (g < 2) ? 1'b1 : 1'b0;
               sy2_r[g] <= (g < 2) ? 1'b1 : 1'b0;
            end else begin
               sy1_r[g] <= async_w[g];
               sy2_r[g] <= sy1_r[g];
            end
         end
      end
   endgenerate
   chgmc_sense_s sn;
   wire          sda_s = sy2_r[0];
   wire          scl_s = sy2_r[1];
   wire          off_s = sy2_r[2];
   assign sn = sy2_r[NS-1:3];

   logic         scl_d_r, sda_d_r;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_w  = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_w   = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // Registers
   logic [7:0] ctrl1_r, float_r, ichg_r, spchg_r, safety_r;
   logic [1:0] status_r;
   logic [2:0] fault_r;
   chgmc_i2c_e st_r;
   logic [7:0] sh_r, ptr_r;
   logic [2:0] bcnt_r;
   logic       rw_r, byte2_r, drive_r, acc_r;
   logic       full_r;
   logic       wr_pulse_r;
   logic [7:0] wdata_r;

   wire [7:0] ctrl0_w = {2'b00, status_r, mode_o == CHGMC_BOOST, 3'b000};
   logic [7:0] rd_mux;
   always_comb begin
      case (ptr_r)
         REG_CTRL0:  rd_mux = ctrl0_w;
         REG_CTRL1:  rd_mux = ctrl1_r;
         REG_FLOAT:  rd_mux = float_r;
         REG_ICHG:   rd_mux = ichg_r;
         REG_SPCHG:  rd_mux = spchg_r;
         REG_SAFETY: rd_mux = safety_r;
         default:    rd_mux = 8'h00;
      endcase
   end

   wire addr_hit = (sh_r[7:1] == SLAVE_ADDR);
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= CHGMC_IDLE;
         sh_r <= 8'h00;
         ptr_r <= 8'h00;
         bcnt_r <= 3'd0;
         rw_r <= 1'b0;
         byte2_r <= 1'b0;
         drive_r <= 1'b0;
         acc_r <= 1'b0;
         wr_pulse_r <= 1'b0;
         wdata_r <= 8'h00;
         full_r <= 1'b0;
      end else begin
         wr_pulse_r <= 1'b0;
         acc_r <= 1'b0;
         if (start_w) begin
            st_r <= CHGMC_ADDR;
            bcnt_r <= 3'd0;
            full_r <= 1'b0;
            drive_r <= 1'b0;
         end else if (stop_w) begin
            st_r <= CHGMC_IDLE;
            drive_r <= 1'b0;
         end else begin
            case (st_r)
               CHGMC_IDLE: drive_r <= 1'b0;
               CHGMC_ADDR, CHGMC_WBYTE: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_s};
                     bcnt_r <= bcnt_r + 3'd1;
                     full_r <= (bcnt_r == 3'd7);
                  end
                  // A byte is whole only after the eighth rise; a wrapped count is not enough
                  if (scl_fall && full_r && st_r == CHGMC_ADDR && addr_hit) begin
                     drive_r <= 1'b1;
                     rw_r <= sh_r[0];
                     byte2_r <= 1'b0;
                     acc_r <= 1'b1;
                     full_r <= 1'b0;
                     st_r <= CHGMC_AACK;
                  end else if (scl_fall && full_r && st_r == CHGMC_ADDR) begin
                     full_r <= 1'b0;
                     st_r <= CHGMC_IDLE;
                  end else if (scl_fall && full_r) begin
                     full_r <= 1'b0;
                     drive_r <= 1'b1;
                     acc_r <= 1'b1;
                     if (!byte2_r) begin
                        ptr_r <= sh_r;
                        byte2_r <= 1'b1;
                     end else begin
                        wdata_r <= sh_r;
                        wr_pulse_r <= 1'b1;
                        ptr_r <= ptr_r + 8'd1;
                     end
                     st_r <= CHGMC_WACK;
                  end
               end
               CHGMC_AACK, CHGMC_WACK: begin
                  if (scl_fall) begin
                     bcnt_r <= 3'd0;
                     sh_r <= 8'hff;
                     if (st_r == CHGMC_AACK && rw_r) begin
                        sh_r <= rd_mux;
                        drive_r <= ~rd_mux[7];
                        st_r <= CHGMC_RBYTE;
                     end else begin
                        drive_r <= 1'b0;
                        st_r <= CHGMC_WBYTE;
                     end
                  end
               end
               CHGMC_RBYTE: begin
                  if (scl_fall) begin
                     bcnt_r <= bcnt_r + 3'd1;
                     sh_r <= {sh_r[6:0], 1'b1};
                     drive_r <= (bcnt_r == 3'd7) ? 1'b0 : ~sh_r[6];
                     if (bcnt_r == 3'd7) st_r <= CHGMC_RACK;
                  end
               end
               CHGMC_RACK: begin
                  if (scl_rise) begin
                     acc_r <= 1'b1;
                     ptr_r <= ptr_r + 8'd1;
                     st_r <= sda_s ? CHGMC_IDLE : CHGMC_AACK;
                  end
               end
               default: st_r <= CHGMC_IDLE;
            endcase
         end
      end
   end
   wire [7:0] wptr_w = ptr_r - 8'd1;

   // Mode decode
   // mode decode
   wire         hiz_w = ctrl1_r[BIT_HIZ];
   wire         opsel_w = ctrl1_r[BIT_OPSEL];
   chgmc_mode_e mode_w;
   assign mode_w = off_s ? CHGMC_OFF :
                   hiz_w ? CHGMC_HIGHZ :
                   opsel_w ? CHGMC_BOOST : CHGMC_CHARGE;

   // VBUS validation and watchdog counters
   logic [31:0] valid_cnt_r;
   logic [36:0] wdog_r;
   logic        vbus_ok_r, ovp_r;
   wire in_window = sn.vbus_min_ok & ~ovp_r;
   wire valid_done = (valid_cnt_r == VALID_CYCLES[31:0]);
   wire wdog_hit = (mode_o == CHGMC_BOOST) && (wdog_r == WDOG_CYCLES[36:0]);
   wire boost_kill = (mode_o == CHGMC_BOOST) && sn.boost_fault;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         valid_cnt_r <= 32'h0000_0000;
         vbus_ok_r <= 1'b0;
         ovp_r <= 1'b0;
         wdog_r <= '0;
      end else begin
         if (sn.vbus_ovp) ovp_r <= 1'b1;
         else if (sn.vbus_ovp_clr) ovp_r <= 1'b0;
         if (!in_window || sn.vbus_ovp) begin
            valid_cnt_r <= 32'h0000_0000;
            vbus_ok_r <= 1'b0;
         end else if (!valid_done) valid_cnt_r <= valid_cnt_r + 32'd1;
         else vbus_ok_r <= 1'b1;
         if (acc_r || mode_o != CHGMC_BOOST) wdog_r <= '0;
         else if (!wdog_hit) wdog_r <= wdog_r + 37'd1;
      end
   end

   // Register file; defaults charge at 4.2V and 500mA
   wire we = wr_pulse_r;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl1_r <= CTRL1_RST;
         float_r <= FLOAT_RST;
         ichg_r <= ICHG_RST;
         spchg_r <= SPCHG_RST;
         safety_r <= SAFETY_RST;
      end else if (wdog_hit) begin
         ctrl1_r <= CTRL1_RST;
         float_r <= FLOAT_RST;
         ichg_r <= ICHG_RST;
         spchg_r <= SPCHG_RST;
         safety_r <= SAFETY_RST;
      end else begin
         if (we && wptr_w == REG_CTRL1) ctrl1_r <= wdata_r;
         if (we && wptr_w == REG_FLOAT) float_r <= wdata_r;
         if (we && wptr_w == REG_ICHG) ichg_r <= wdata_r;
         if (we && wptr_w == REG_SPCHG) spchg_r <= wdata_r;
         if (we && wptr_w == REG_SAFETY) safety_r <= wdata_r;
         if (boost_kill || (opsel_w && hiz_w)) ctrl1_r[BIT_OPSEL] <= 1'b0;
      end
   end

   // Charge control and boost sequencing
   wire charge_mode = (mode_w == CHGMC_CHARGE) || (mode_w == CHGMC_HIGHZ);
   logic no_bat_seen_r;
   logic [11:0] ss_r;
   logic [4:0]  pulse_r;
   logic        skip_r;
   logic        ss_on_r;
   wire can_charge = charge_mode & vbus_ok_r & sn.vbus_min_ok & ~ovp_r & ~sn.over_temp;
   wire pwm_stop_w = no_bat_seen_r & ~ctrl1_r[BIT_CUTOFF] & sn.bat_present
                     & sn.bat_above_float;
   wire done_w = ctrl1_r[BIT_CUTOFF] & sn.below_term & vbus_ok_r;
   wire boost_on = (mode_w == CHGMC_BOOST);
   wire ss_done = (ss_r == SS_CYC[11:0]);
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_o <= CHGMC_CHARGE;
         charge_en_o <= 1'b0;
         ramp_up_o <= 1'b0;
         hold_floor_o <= 1'b0;
         pwm_stop_o <= 1'b0;
         no_bat_seen_r <= 1'b0;
         status_r <= ST_READY;
         fault_r <= FAULT_NONE;
         ss_r <= 12'h000;
         pulse_r <= 5'd0;
         skip_r <= 1'b0;
         ss_on_r <= 1'b0;
         boost_switch_o <= 1'b0;
         status_pin_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         mode_o <= mode_w;
         // open drain, low only while driving
         sda_o <= 1'b0;
         sda_oe_o <= drive_r;
         if (!sn.bat_present) no_bat_seen_r <= 1'b1;
         else if (!sn.bat_above_float) no_bat_seen_r <= 1'b0;
         pwm_stop_o <= pwm_stop_w;
         charge_en_o <= can_charge & ~pwm_stop_w & ~done_w;
         // ramp until a cap or floor
         ramp_up_o <= can_charge & ~sn.cap_reached & ~sn.at_floor;
         hold_floor_o <= can_charge & sn.at_floor;
         if (sn.over_temp) fault_r <= FAULT_THERMAL;
         else if (ovp_r) fault_r <= FAULT_OVP;
         else if (charge_mode && !sn.vbus_min_ok) fault_r <= FAULT_UVLO;
         else if (boost_kill) fault_r <= FAULT_BOOST;
         else fault_r <= FAULT_NONE;
         if (sn.over_temp || ovp_r || boost_kill) status_r <= ST_FAULT;
         else if (done_w) status_r <= ST_DONE;
         else if (can_charge) status_r <= ST_CHARGING;
         else status_r <= ST_READY;
         if (!boost_on) ss_r <= 12'h000;
         else if (!ss_done) ss_r <= ss_r + 12'd1;
         ss_on_r <= boost_on & ~ss_done;
         skip_r <= boost_on & sn.vbus_above_ref;
         boost_switch_o <= boost_on & ~sn.fb_above_ref & ~sn.vbus_above_ref;
         if (boost_kill) pulse_r <= STAT_PULSE_CYC[4:0];
         else if (pulse_r != 5'd0) pulse_r <= pulse_r - 5'd1;
         status_pin_o <= (pulse_r != 5'd0);
      end
   end
   assign pulse_skip_regime_o = skip_r;
   assign long_on_time_o = skip_r;
   assign soft_start_o = ss_on_r;
   assign peak_limit_150_o = ss_on_r;
   assign input_current_cap_o = ctrl1_r[7:6];
   assign charge_current_cap_o = ichg_r[6:4];
   assign float_voltage_setting_o = float_r[7:2];
   assign input_voltage_floor_o = spchg_r[2:0];
   assign status_o = status_r;
   assign fault_code_o = fault_r;
endmodule : chgmc_top
`default_nettype wire

// *** design/chgmc_pkg.sv ***
/*
 Shared constants and carriers for the charger mode control block.
 Assumes a 40 MHz core clock; analog comparators arrive as levels.
*/
package chgmc_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   // Long durations kept in their own units
   localparam int unsigned VALID_MS = 25;
   localparam int unsigned WDOG_S = 32;
   localparam int unsigned SS_US = 50;
   localparam int unsigned VALID_CYC = VALID_MS * (CLK_HZ / 1000);
   localparam longint unsigned WDOG_CYC = longint'(WDOG_S) * longint'(CLK_HZ);
   localparam int unsigned SS_CYC = SS_US * (CLK_HZ / 1_000_000);
   localparam int unsigned STAT_PULSE_CYC = 16;
   localparam logic [6:0] SLAVE_ADDR = 7'h6a;
   localparam logic [7:0] REG_CTRL0 = 8'h00;
   localparam logic [7:0] REG_CTRL1 = 8'h01;
   localparam logic [7:0] REG_FLOAT = 8'h02;
   localparam logic [7:0] REG_ICHG = 8'h04;
   localparam logic [7:0] REG_SPCHG = 8'h05;
   localparam logic [7:0] REG_SAFETY = 8'h06;
   localparam logic [7:0] CTRL1_RST = 8'h70;
   localparam logic [7:0] FLOAT_RST = 8'h00;
   localparam logic [7:0] ICHG_RST = 8'h00;
   localparam logic [7:0] SPCHG_RST = 8'h04;
   localparam logic [7:0] SAFETY_RST = 8'h00;
   localparam int unsigned BIT_OPSEL = 0;
   localparam int unsigned BIT_HIZ = 1;
   localparam int unsigned BIT_CUTOFF = 3;
   localparam logic [1:0] CAP_500MA = 2'b01;
   localparam logic [1:0] ST_READY = 2'b00;
   localparam logic [1:0] ST_CHARGING = 2'b01;
   localparam logic [1:0] ST_DONE = 2'b10;
   localparam logic [1:0] ST_FAULT = 2'b11;
   localparam logic [2:0] FAULT_NONE = 3'b000;
   localparam logic [2:0] FAULT_THERMAL = 3'b101;
   localparam logic [2:0] FAULT_OVP = 3'b001;
   localparam logic [2:0] FAULT_UVLO = 3'b011;
   localparam logic [2:0] FAULT_BOOST = 3'b110;

   typedef enum logic [1:0] {
      CHGMC_CHARGE  = 2'b00,
      CHGMC_OFF     = 2'b01,
      CHGMC_BOOST   = 2'b10,
      CHGMC_HIGHZ   = 2'b11
   } chgmc_mode_e;

   typedef enum logic [2:0] {
      CHGMC_IDLE  = 3'b000,
      CHGMC_ADDR  = 3'b001,
      CHGMC_AACK  = 3'b010,
      CHGMC_WBYTE = 3'b011,
      CHGMC_WACK  = 3'b100,
      CHGMC_RBYTE = 3'b101,
      CHGMC_RACK  = 3'b110
   } chgmc_i2c_e;

   // Analog comparator levels from the power stage
   typedef struct packed {
      logic vbus_min_ok;
      logic vbus_ovp;
      logic vbus_ovp_clr;
      logic at_floor;
      logic cap_reached;
      logic over_temp;
      logic below_term;
      logic bat_above_float;
      logic bat_present;
      logic vbus_above_ref;
      logic fb_above_ref;
      logic boost_fault;
   } chgmc_sense_s;
endpackage : chgmc_pkg

// *** test/chgmc_host_model.sv ***
/*
 Behavioural I2C bus master that stands in for the host processor.
 Assumes the testbench resolves SDA as a pulled-up open-drain wire.
*/
`timescale 1ns/10ps
`default_nettype none
module chgmc_host_model (
   output logic      scl_o,
   output logic      sda_rel_o,
   input  wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   // data moves while clock low
   // Long low phase leaves room for the slave's synchroniser delay
   task automatic clk_bit(input logic b, output logic s);
      #20 sda_rel_o = b;
      #130 scl_o = 1'b1;
      #25 s = sda_i;
      #25 scl_o = 1'b0;
   endtask : clk_bit
   task automatic start_cond();
      #20 sda_rel_o = 1'b1;
      #130 scl_o = 1'b1;
      #25 sda_rel_o = 1'b0;
      #25 scl_o = 1'b0;
   endtask : start_cond
   task automatic stop_cond();
      #20 sda_rel_o = 1'b0;
      #130 scl_o = 1'b1;
      #25 sda_rel_o = 1'b1;
      #25;
   endtask : stop_cond
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, s);
      ack = ~s;
   endtask : put_byte
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, d[i]);
      end
      clk_bit(nack, s);
   endtask : get_byte
   task automatic write_reg(input logic [7:0] dev, rg, dat, output logic ok);
      logic a0, a1, a2;
      start_cond();
      put_byte(dev, a0);
      put_byte(rg, a1);
      put_byte(dat, a2);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask : write_reg
   // repeated start, then NACK ends the read
   task automatic read_reg(input logic [7:0] rg, output logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start_cond();
      put_byte(8'hd4, a0);
      put_byte(rg, a1);
      start_cond();
      put_byte(8'hd5, a2);
      get_byte(1'b1, d);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask : read_reg
endmodule : chgmc_host_model
`default_nettype wire

// *** test/chgmc_top_props.sv ***
/*
 Concurrent checks on the charger mode control ports.
 Bound into chgmc_top; sees its ports only, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module chgmc_top_props
   import chgmc_pkg::*;
(
   input wire logic         ref_clk_i,
   input wire logic         rst_b_i,
   input wire logic         scl_i,
   input wire logic         sda_o,
   input wire logic         sda_oe_o,
   input wire logic         charger_off_i,
   input wire chgmc_sense_s sense_i,
   input wire chgmc_mode_e  mode_o,
   input wire logic         charge_en_o,
   input wire logic         ramp_up_o,
   input wire logic [2:0]   fault_code_o,
   input wire logic [2:0]   input_voltage_floor_o,
   input wire logic         status_pin_o,
   input wire logic         boost_switch_o,
   input wire logic         soft_start_o,
   input wire logic         peak_limit_150_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   property p_sda_low; sda_o == 1'b0; endproperty
   a_sda_low: assert property (p_sda_low) else $error("sda data not low");
   property p_ack_edge; $changed(sda_oe_o) |-> !scl_i; endproperty
   a_ack_edge: assert property (p_ack_edge) else $error("sda moved with scl high");
   property p_floor_rst; $rose(rst_b_i) |-> input_voltage_floor_o == 3'b100; endproperty
   a_floor_rst: assert property (p_floor_rst) else $error("floor reset wrong");
   property p_off; charger_off_i[*5] |-> mode_o == CHGMC_OFF; endproperty
   a_off: assert property (p_off) else $error("pin did not disable");
   property p_therm;
      sense_i.over_temp[*5] |-> !charge_en_o && fault_code_o == FAULT_THERMAL;
   endproperty
   a_therm: assert property (p_therm) else $error("thermal trip missed");
   property p_uvlo; (!sense_i.vbus_min_ok)[*5] |-> !charge_en_o; endproperty
   a_uvlo: assert property (p_uvlo) else $error("charging on low vbus");
   property p_ovp; sense_i.vbus_ovp[*5] |-> !charge_en_o; endproperty
   a_ovp: assert property (p_ovp) else $error("charging in overvoltage");
   property p_ramp; (sense_i.cap_reached || sense_i.at_floor)[*5] |-> !ramp_up_o; endproperty
   a_ramp: assert property (p_ramp) else $error("ramp did not stop");
   property p_sw_off;
      (sense_i.fb_above_ref || sense_i.vbus_above_ref)[*5] |-> !boost_switch_o;
   endproperty
   a_sw_off: assert property (p_sw_off) else $error("boost switch on");
   property p_ss; peak_limit_150_o == soft_start_o; endproperty
   a_ss: assert property (p_ss) else $error("peak limit not tied to soft start");
   property p_pin; $rose(status_pin_o) |=> status_pin_o[*8]; endproperty
   a_pin: assert property (p_pin) else $error("status pulse too short");
   property p_valid; $rose(charge_en_o) |-> $past(sense_i.vbus_min_ok, 8); endproperty
   a_valid: assert property (p_valid) else $error("charge without valid vbus");
endmodule : chgmc_top_props
bind chgmc_top chgmc_top_props props_u (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .charger_off_i(charger_off_i), .sense_i(sense_i),
   .mode_o(mode_o), .charge_en_o(charge_en_o), .ramp_up_o(ramp_up_o),
   .fault_code_o(fault_code_o), .input_voltage_floor_o(input_voltage_floor_o),
   .status_pin_o(status_pin_o), .boost_switch_o(boost_switch_o),
   .soft_start_o(soft_start_o), .peak_limit_150_o(peak_limit_150_o)
);
`default_nettype wire

// *** test/testbench.sv ***
/*
 Self-checking bench for the charger mode control block.
 Assumes the host model for I2C; sense levels are driven directly.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import chgmc_pkg::*;
   // Short counts keep the run brief
   localparam int unsigned     VALID_N = 100;
   localparam longint unsigned WDOG_N = 1000;
   logic         ref_clk;
   logic         rst_b;
   logic         charger_off;
   chgmc_sense_s sense;
   logic         scl;
   logic         sda_rel;
   logic         sda_oe;
   chgmc_mode_e  mode;
   logic         charge_en;
   logic [1:0]   icap;
   logic [5:0]   vfloat;
   logic [2:0]   floor_v;
   logic [1:0]   status;
   logic [2:0]   fault;
   logic         stat_pin;
   logic         bsw;
   logic         ramp;
   logic         hold;
   logic         pwm;
   logic         skip;
   logic         sst;
   logic         sda_dv;
   int           miscompares = 0;
   int           checked = 0;
   // Pulled up: low whenever either party pulls
   wire logic    sda = (~sda_oe | sda_dv) & sda_rel;
   chgmc_top #(.VALID_CYCLES(VALID_N), .WDOG_CYCLES(WDOG_N)) dut_u (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_dv),
      .sda_oe_o(sda_oe), .charger_off_i(charger_off), .sense_i(sense), .mode_o(mode),
      .charge_en_o(charge_en), .ramp_up_o(ramp), .hold_floor_o(hold), .pwm_stop_o(pwm),
      .input_current_cap_o(icap), .charge_current_cap_o(),
      .float_voltage_setting_o(vfloat), .input_voltage_floor_o(floor_v),
      .status_o(status), .fault_code_o(fault), .status_pin_o(stat_pin),
      .boost_switch_o(bsw), .pulse_skip_regime_o(skip), .long_on_time_o(),
      .soft_start_o(sst), .peak_limit_150_o()
   );
   chgmc_host_model host_u (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : cmp
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : cyc
   task automatic wr(input logic [7:0] rg, dat);
      logic ok;
      host_u.write_reg(8'hd4, rg, dat, ok);
      cmp("write ack", 8'h01, {7'h0, ok});
   endtask : wr
   task automatic rd(input logic [7:0] rg, output logic [7:0] d);
      logic ok;
      host_u.read_reg(rg, d, ok);
      cmp("read ack", 8'h01, {7'h0, ok});
   endtask : rd
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   initial begin
      #1ms;
      miscompares++;
      give_verdict();
   end
   initial begin : main
      logic ok;
      logic [7:0] d;
      rst_b = 1'b0;
      charger_off = 1'b0;
      sense = '0;
      cyc(12);
      rst_b = 1'b1;
      cyc(4);
      cmp("floor reset", 8'h04, {5'h0, floor_v});
      cmp("cap reset", 8'h01, {6'h0, icap});
      host_u.write_reg(8'hd6, 8'h05, 8'h00, ok);
      cmp("foreign ack", 8'h00, {7'h0, ok});
      cmp("foreign write", 8'h04, {5'h0, floor_v});
      for (int i = 0; i < 8; i++) begin
         wr(8'h05, 8'(i));
         rd(8'h05, d);
         cmp("floor read", 8'(i), d);
         cmp("floor port", 8'(i), {5'h0, floor_v});
      end
      wr(8'h06, 8'h00);
      wr(8'h01, 8'hc0);
      cmp("cap open", 8'h03, {6'h0, icap});
      wr(8'h02, 8'h08);
      cmp("float", 8'h02, {2'h0, vfloat});
      wr(8'h01, 8'h40);
      cmp("cap 500", 8'h01, {6'h0, icap});
      sense.vbus_min_ok = 1'b1;
      sense.vbus_ovp_clr = 1'b1;
      sense.bat_present = 1'b1;
      cyc(VALID_N - 10);
      cmp("early charge", 8'h00, {7'h0, charge_en});
      cyc(20);
      cmp("charge on", 8'h01, {7'h0, charge_en});
      rd(8'h00, d);
      cmp("status reg", {6'h0, ST_CHARGING}, {6'h0, d[5:4]});
      cmp("status port", {6'h0, ST_CHARGING}, {6'h0, status});
      sense.cap_reached = 1'b1;
      cyc(8);
      cmp("ramp stop", 8'h00, {7'h0, ramp});
      sense.cap_reached = 1'b0;
      sense.at_floor = 1'b1;
      cyc(8);
      cmp("hold floor", 8'h01, {7'h0, hold});
      sense.at_floor = 1'b0;
      sense.over_temp = 1'b1;
      cyc(8);
      cmp("thermal code", 8'h05, {5'h0, fault});
      sense.over_temp = 1'b0;
      sense.vbus_ovp = 1'b1;
      sense.vbus_ovp_clr = 1'b0;
      cyc(8);
      cmp("ovp stop", 8'h00, {7'h0, charge_en});
      sense.vbus_ovp = 1'b0;
      cyc(VALID_N + 20);
      cmp("ovp hysteresis", 8'h00, {7'h0, charge_en});
      sense.vbus_ovp_clr = 1'b1;
      cyc(VALID_N - 10);
      cmp("revalid early", 8'h00, {7'h0, charge_en});
      cyc(20);
      cmp("revalid", 8'h01, {7'h0, charge_en});
      wr(8'h01, 8'h48);
      sense.below_term = 1'b1;
      cyc(8);
      cmp("done code", 8'h02, {6'h0, status});
      sense.below_term = 1'b0;
      sense.vbus_min_ok = 1'b0;
      cyc(8);
      cmp("uvlo stop", 8'h00, {7'h0, charge_en});
      wr(8'h01, 8'h41);
      cmp("boost", {6'h0, CHGMC_BOOST}, {6'h0, mode});
      cmp("soft start", 8'h01, {7'h0, sst});
      sense.fb_above_ref = 1'b1;
      cyc(8);
      cmp("fb off", 8'h00, {7'h0, bsw});
      sense.fb_above_ref = 1'b0;
      sense.vbus_above_ref = 1'b1;
      cyc(8);
      cmp("skip off", 8'h00, {7'h0, bsw});
      cmp("skip", 8'h01, {7'h0, skip});
      sense.vbus_above_ref = 1'b0;
      cyc(8);
      cmp("switch on", 8'h01, {7'h0, bsw});
      wr(8'h01, 8'h43);
      cmp("high z", {6'h0, CHGMC_HIGHZ}, {6'h0, mode});
      rd(8'h01, d);
      cmp("opsel cleared", 8'h42, d);
      wr(8'h01, 8'h41);
      sense.boost_fault = 1'b1;
      cyc(8);
      cmp("fault pulse", 8'h01, {7'h0, stat_pin});
      sense.boost_fault = 1'b0;
      rd(8'h01, d);
      cmp("fault opsel", 8'h40, d);
      charger_off = 1'b1;
      cyc(8);
      cmp("off", {6'h0, CHGMC_OFF}, {6'h0, mode});
      charger_off = 1'b0;
      cyc(8);
      cmp("charge mode", {6'h0, CHGMC_CHARGE}, {6'h0, mode});
      sense.bat_present = 1'b0;
      cyc(8);
      sense.bat_present = 1'b1;
      sense.bat_above_float = 1'b1;
      cyc(8);
      cmp("pwm stop", 8'h01, {7'h0, pwm});
      wr(8'h05, 8'h07);
      wr(8'h01, 8'h41);
      cyc(900);
      cmp("idle boost", {6'h0, CHGMC_BOOST}, {6'h0, mode});
      cyc(150);
      cmp("expired mode", {6'h0, CHGMC_CHARGE}, {6'h0, mode});
      cmp("expired floor", 8'h04, {5'h0, floor_v});
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
